// ==== rtl/lsu_pkg.sv ====
// Purpose: Shared constants and types of the load/store unit.
// Assumes: 16-bit instruction encodings, 32-bit little-endian data.
// Notes: Access size codes travel on the memory bus unchanged.
package lsu_pkg;
   typedef logic [1:0] lsu_size_t;
   localparam lsu_size_t SZ_BYTE = 2'h0;
   localparam lsu_size_t SZ_HALF = 2'h1;
   localparam lsu_size_t SZ_WORD = 2'h2;

   // Pipeline offset of the program counter seen by literal loads.
   localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
   localparam logic [31:0] WORD_MASK = 32'hffff_fffc;

   localparam logic [3:0] REG_SP = 4'hd;
   localparam logic [3:0] REG_LR = 4'he;
   localparam logic [3:0] REG_PC = 4'hf;

   // Major opcode fields, matched on instruction bits 15:11, 15:12 or 15:13; STACK_SEL on bits 10:9.
   localparam logic [4:0] OP_LIT = 5'h09;
   localparam logic [3:0] OP_REGOFS = 4'h5;
   localparam logic [2:0] OP_IMM_WB = 3'h3;
   localparam logic [3:0] OP_IMM_H = 4'h8;
   localparam logic [3:0] OP_SP_W = 4'h9;
   localparam logic [3:0] OP_MULTI = 4'hc;
   localparam logic [3:0] OP_STACK = 4'hb;
   localparam logic [1:0] STACK_SEL = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_XFER = 2'b01,
      ST_WBACK = 2'b10
   } lsu_state_e;
endpackage

// ==== rtl/lsu_dec_if.sv ====
// Purpose: Carries the decoded access from the decoder to the sequencer.
// Assumes: Purely combinational contents, valid while the opcode is held.
// Notes: None.
`timescale 1ns/10ps
interface lsu_dec_if;
   logic valid;
   logic misalign;
   logic multi;
   logic load;
   logic signd;
   logic [1:0] size;
   logic [2:0] rt;
   logic [2:0] rn;
   logic [31:0] addr;
   logic [7:0] list;
   logic extra;
   logic push;
   logic pop;
   logic wb;
   logic [31:0] wb_val;
   logic [31:0] st_val;
   modport dec (output valid, misalign, multi, load, signd, size, rt, rn,
      addr, list, extra, push, pop, wb, wb_val, st_val);
   modport ctl (input valid, misalign, multi, load, signd, size, rt, rn,
      addr, list, extra, push, pop, wb, wb_val, st_val);
endinterface

// ==== rtl/lsu_align.sv ====
// Purpose: Extends loaded data and trims store data to the access size.
// Assumes: Data sits in the low bits of the word bus.
// Notes: Combinational only.
`timescale 1ns/10ps
module lsu_align (
   input wire logic [31:0] i_ld_raw,
   input wire logic [31:0] i_st_raw,
   input wire logic [1:0] i_size,
   input wire logic i_signd,
   output logic [31:0] o_ld,
   output logic [31:0] o_st
);
   import lsu_pkg::*;
   always_comb begin
      o_ld = i_ld_raw;
      o_st = i_st_raw;
      unique case (i_size)
         SZ_BYTE: begin
            o_ld = {{24{i_signd & i_ld_raw[7]}}, i_ld_raw[7:0]};
            o_st = {24'h0, i_st_raw[7:0]};
         end
         SZ_HALF: begin
            o_ld = {{16{i_signd & i_ld_raw[15]}}, i_ld_raw[15:0]};
            o_st = {16'h0, i_st_raw[15:0]};
         end
         default: begin
            o_ld = i_ld_raw;
            o_st = i_st_raw;
         end
      endcase
   end
endmodule

// ==== rtl/lsu_decode.sv ====
// Purpose: Decodes memory access opcodes and forms the first address.
// Assumes: Register contents are presented flat by the core.
// Notes: Opcodes outside the memory access group leave valid low.
`timescale 1ns/10ps
module lsu_decode (
   input wire logic [15:0] i_instr,
   input wire logic [31:0] i_pc,
   input wire logic [31:0] i_sp,
   input wire logic [255:0] i_lo_regs,
   lsu_dec_if.dec dec
);
   import lsu_pkg::*;
   logic [31:0] rn_v;
   logic [31:0] rm_v;
   logic [31:0] n4;
   logic [3:0] cnt;
   logic [2:0] op;

   always_comb begin
      rn_v = i_lo_regs[{i_instr[5:3], 5'h0} +: 32];
      rm_v = i_lo_regs[{i_instr[8:6], 5'h0} +: 32];
      op = i_instr[11:9];
      dec.valid = 1'b0;
      dec.multi = 1'b0;
      dec.load = i_instr[11];
      dec.signd = 1'b0;
      dec.size = SZ_WORD;
      dec.rt = i_instr[2:0];
      dec.rn = i_instr[5:3];
      dec.addr = 32'h0;
      dec.list = 8'h0;
      dec.extra = 1'b0;
      dec.push = 1'b0;
      dec.pop = 1'b0;
      dec.wb = 1'b0;
      if (i_instr[15:11] == OP_LIT) begin
         dec.valid = 1'b1;
         dec.load = 1'b1;
         dec.rt = i_instr[10:8];
         dec.addr = ((i_pc + PC_AHEAD) & WORD_MASK)
            + {22'h0, i_instr[7:0], 2'h0};
      end else if (i_instr[15:12] == OP_REGOFS) begin
         dec.valid = 1'b1;
         dec.load = op[2] | (op == 3'h3);
         dec.signd = (op == 3'h3) | (op == 3'h7);
         dec.size = (op == 3'h0 || op == 3'h4) ? SZ_WORD :
            (op == 3'h1 || op == 3'h5 || op == 3'h7) ? SZ_HALF : SZ_BYTE;
         dec.addr = rn_v + rm_v;
      end else if (i_instr[15:13] == OP_IMM_WB) begin
         dec.valid = 1'b1;
         dec.size = i_instr[12] ? SZ_BYTE : SZ_WORD;
         // A five-bit field caps offsets at 124 (word) and 31 (byte).
         dec.addr = i_instr[12] ? rn_v + {27'h0, i_instr[10:6]}
            : rn_v + {25'h0, i_instr[10:6], 2'h0};
      end else if (i_instr[15:12] == OP_IMM_H) begin
         dec.valid = 1'b1;
         dec.size = SZ_HALF;
         dec.addr = rn_v + {26'h0, i_instr[10:6], 1'b0};
      end else if (i_instr[15:12] == OP_SP_W) begin
         dec.valid = 1'b1;
         dec.rt = i_instr[10:8];
         dec.addr = i_sp + {22'h0, i_instr[7:0], 2'h0};
      end else if (i_instr[15:12] == OP_MULTI) begin
         dec.multi = 1'b1;
         dec.rn = i_instr[10:8];
         dec.list = i_instr[7:0];
         dec.valid = (i_instr[7:0] != 8'h0);
         dec.wb = ~i_instr[11] | ~i_instr[i_instr[10:8]];
         dec.addr = i_lo_regs[{i_instr[10:8], 5'h0} +: 32];
      end else if (i_instr[15:12] == OP_STACK
            && i_instr[10:9] == STACK_SEL) begin
         dec.multi = 1'b1;
         dec.list = i_instr[7:0];
         dec.extra = i_instr[8];
         dec.push = ~i_instr[11];
         dec.pop = i_instr[11];
         dec.wb = 1'b1;
         dec.valid = (i_instr[8:0] != 9'h0);
      end
      cnt = {3'h0, dec.extra};
      for (int k = 0; k < 8; k++) begin
         cnt = cnt + {3'h0, dec.list[k]};
      end
      n4 = {26'h0, cnt, 2'h0};
      if (dec.push) begin
         dec.addr = i_sp - n4;
      end else if (dec.pop) begin
         dec.addr = i_sp;
      end
      dec.wb_val = dec.push ? i_sp - n4 : dec.addr + n4;
      dec.misalign = (dec.size == SZ_WORD) ? (dec.addr[1:0] != 2'h0) :
         (dec.size == SZ_HALF) ? dec.addr[0] : 1'b0;
      dec.st_val = i_lo_regs[{dec.rt, 5'h0} +: 32];
   end
endmodule

// ==== rtl/lsu_unit.sv ====
// Purpose: Load/store unit sequencing single, multiple and stack accesses.
// Assumes: The core holds i_instr and register contents while o_busy is
//    high, and updates i_lo_regs, i_sp from o_rf_* writes.
// Notes: One access is outstanding at a time; requests hold until ack.
//
// Summary of operation
// - An omitted immediate offset is treated as zero.
// - Immediate-form byte and halfword loads are zero extended to 32 bits.
// - Stores write whole word, bits 7:0 or bits 15:0 by size.
// - Immediate address is low register or stack pointer plus offset.
// - Word offsets step by four, up to 1020 on SP, 124 otherwise.
// - Halfword offsets even up to 62; byte offsets up to 31.
// - Immediate-form addresses must be aligned to the access size.
// - No memory instruction alters the N, Z, C or V flags.
// - Register-offset loads give word, zero or sign extended byte/half.
// - Register-offset address is base plus offset register value.
// - Literal load reads a word-aligned word near the program counter.
// - Multiple transfers use consecutive words from the base upward.
// - Lowest register goes to lowest address, ascending order.
// - Writeback stores base plus four times the register count.
// - Writeback always, except a multiple load that lists its base.
// - Multiple transfers use only low registers for base and list.
// - Multiple transfer base address must be word aligned.
// - A stored base register must be lowest, else its value is undefined.
// - Push ends at SP minus four; pop starts at SP.
// - Push leaves SP at lowest store; pop one word above last load.
// - Popping the PC branches afterwards; bit 0 sets the Thumb bit.
// - Push may add the link register, pop may add the PC.
// - PC-relative base is current instruction address plus four.
`timescale 1ns/10ps
module lsu_unit (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic [15:0] i_instr,
   input wire logic [31:0] i_pc,
   input wire logic [31:0] i_sp,
   input wire logic [31:0] i_lr,
   input wire logic [255:0] i_lo_regs,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata,
   output logic o_mem_req,
   output logic o_mem_we,
   output logic [31:0] o_mem_addr,
   output lsu_pkg::lsu_size_t o_mem_size,
   output logic [31:0] o_mem_wdata,
   output logic o_rf_we,
   output logic [3:0] o_rf_waddr,
   output logic [31:0] o_rf_wdata,
   output logic o_busy,
   output logic o_done,
   output logic o_fault,
   output logic o_branch,
   output logic [31:0] o_branch_addr,
   output logic o_tbit,
   output logic o_flags_we
);
   import lsu_pkg::*;

   lsu_dec_if dif ();

   lsu_state_e state_q, state_d;
   logic req_q, req_d;
   logic we_q, we_d;
   logic [31:0] addr_q, addr_d;
   lsu_size_t size_q, size_d;
   logic [31:0] wdata_q, wdata_d;
   logic rf_we_q, rf_we_d;
   logic [3:0] rf_waddr_q, rf_waddr_d;
   logic [31:0] rf_wdata_q, rf_wdata_d;
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic fault_q, fault_d;
   logic branch_q, branch_d;
   logic [31:0] tgt_q, tgt_d;
   logic flags_we_q;

   logic signd_q, signd_d;
   logic multi_q, multi_d;
   logic [2:0] rt_q, rt_d;
   logic [8:0] left_q, left_d;
   logic [3:0] cur_q, cur_d;
   logic xreg_pc_q, xreg_pc_d;
   logic wb_q, wb_d;
   logic [3:0] wb_reg_q, wb_reg_d;
   logic [31:0] wb_val_q, wb_val_d;
   logic pc_hit_q, pc_hit_d;

   logic [8:0] rest;
   logic [3:0] nxt;
   logic [31:0] st_src;
   logic [31:0] ld_ext;
   logic [31:0] st_fmt;
   lsu_size_t fmt_size;
   logic fmt_signd;
   logic start;

   lsu_decode u_dec (
      .i_instr(i_instr),
      .i_pc(i_pc),
      .i_sp(i_sp),
      .i_lo_regs(i_lo_regs),
      .dec(dif.dec)
   );

   lsu_align u_align (
      .i_ld_raw(i_mem_rdata),
      .i_st_raw(st_src),
      .i_size(fmt_size),
      .i_signd(fmt_signd),
      .o_ld(ld_ext),
      .o_st(st_fmt)
   );

   // Index of the lowest pending entry; entry 8 stands for LR or PC.
   function automatic logic [3:0] lowest(input logic [8:0] bits);
      logic [3:0] idx;
      idx = 4'h8;
      for (int k = 8; k >= 0; k--) begin
         if (bits[k]) begin
            idx = 4'(k);
         end
      end
      return idx;
   endfunction

   // Register value for a store; entry 8 maps to the link register.
   function automatic logic [31:0] reg_val(input logic [3:0] idx);
      logic [31:0] v;
      v = (idx == 4'h8) ? i_lr : i_lo_regs[{idx[2:0], 5'h0} +: 32];
      return v;
   endfunction

   always_comb begin
      start = i_start & (state_q == ST_IDLE);
      fmt_size = (state_q == ST_IDLE) ? dif.size : size_q;
      fmt_signd = signd_q;
      rest = left_q & ~(9'h001 << cur_q);
      nxt = lowest(rest);
      st_src = (state_q == ST_IDLE) ?
         (dif.multi ? reg_val(lowest({dif.extra, dif.list})) : dif.st_val)
         : reg_val(nxt);
   end

   always_comb begin
      state_d = state_q;
      req_d = req_q;
      we_d = we_q;
      addr_d = addr_q;
      size_d = size_q;
      wdata_d = wdata_q;
      rf_we_d = 1'b0;
      rf_waddr_d = rf_waddr_q;
      rf_wdata_d = rf_wdata_q;
      done_d = 1'b0;
      fault_d = 1'b0;
      branch_d = 1'b0;
      tgt_d = tgt_q;
      signd_d = signd_q;
      multi_d = multi_q;
      rt_d = rt_q;
      left_d = left_q;
      cur_d = cur_q;
      xreg_pc_d = xreg_pc_q;
      wb_d = wb_q;
      wb_reg_d = wb_reg_q;
      wb_val_d = wb_val_q;
      pc_hit_d = pc_hit_q;
      unique case (state_q)
         ST_IDLE: begin
            if (start && !dif.valid) begin
               done_d = 1'b1;
            end else if (start && dif.misalign) begin
               fault_d = 1'b1;
               done_d = 1'b1;
            end else if (start) begin
               req_d = 1'b1;
               we_d = ~dif.load;
               addr_d = dif.addr;
               size_d = dif.size;
               wdata_d = st_fmt;
               signd_d = dif.signd;
               multi_d = dif.multi;
               rt_d = dif.rt;
               left_d = {dif.extra, dif.list};
               cur_d = lowest({dif.extra, dif.list});
               xreg_pc_d = dif.pop;
               wb_d = dif.wb;
               wb_reg_d = (dif.push | dif.pop) ? REG_SP : {1'b0, dif.rn};
               wb_val_d = dif.wb_val;
               pc_hit_d = 1'b0;
               state_d = ST_XFER;
            end
         end
         ST_XFER: begin
            if (i_mem_ack) begin
               if (!we_q && multi_q && cur_q == 4'h8 && xreg_pc_q) begin
                  tgt_d = ld_ext;
                  pc_hit_d = 1'b1;
               end else if (!we_q) begin
                  rf_we_d = 1'b1;
                  rf_waddr_d = multi_q ? cur_q : {1'b0, rt_q};
                  rf_wdata_d = ld_ext;
               end
               if (multi_q && rest != 9'h0) begin
                  left_d = rest;
                  cur_d = nxt;
                  addr_d = addr_q + 32'h4;
                  wdata_d = st_fmt;
               end else if (multi_q && wb_q) begin
                  req_d = 1'b0;
                  state_d = ST_WBACK;
               end else begin
                  req_d = 1'b0;
                  done_d = 1'b1;
                  branch_d = pc_hit_d;
                  state_d = ST_IDLE;
               end
            end
         end
         ST_WBACK: begin
            rf_we_d = 1'b1;
            rf_waddr_d = wb_reg_q;
            rf_wdata_d = wb_val_q;
            done_d = 1'b1;
            branch_d = pc_hit_q;
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      busy_d = (state_d != ST_IDLE);
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 32'h0;
         size_q <= SZ_WORD;
         wdata_q <= 32'h0;
         rf_we_q <= 1'b0;
         rf_waddr_q <= 4'h0;
         rf_wdata_q <= 32'h0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         fault_q <= 1'b0;
         branch_q <= 1'b0;
         tgt_q <= 32'h0;
         flags_we_q <= 1'b0;
         signd_q <= 1'b0;
         multi_q <= 1'b0;
         rt_q <= 3'h0;
         left_q <= 9'h0;
         cur_q <= 4'h0;
         xreg_pc_q <= 1'b0;
         wb_q <= 1'b0;
         wb_reg_q <= 4'h0;
         wb_val_q <= 32'h0;
         pc_hit_q <= 1'b0;
      end else begin
         state_q <= state_d;
         req_q <= req_d;
         we_q <= we_d;
         addr_q <= addr_d;
         size_q <= size_d;
         wdata_q <= wdata_d;
         rf_we_q <= rf_we_d;
         rf_waddr_q <= rf_waddr_d;
         rf_wdata_q <= rf_wdata_d;
         busy_q <= busy_d;
         done_q <= done_d;
         fault_q <= fault_d;
         branch_q <= branch_d;
         tgt_q <= tgt_d;
         // The flag write strobe is never raised by this unit.
         flags_we_q <= 1'b0;
         signd_q <= signd_d;
         multi_q <= multi_d;
         rt_q <= rt_d;
         left_q <= left_d;
         cur_q <= cur_d;
         xreg_pc_q <= xreg_pc_d;
         wb_q <= wb_d;
         wb_reg_q <= wb_reg_d;
         wb_val_q <= wb_val_d;
         pc_hit_q <= pc_hit_d;
      end
   end

   assign o_mem_req = req_q;
   assign o_mem_we = we_q;
   assign o_mem_addr = addr_q;
   assign o_mem_size = size_q;
   assign o_mem_wdata = wdata_q;
   assign o_rf_we = rf_we_q;
   assign o_rf_waddr = rf_waddr_q;
   assign o_rf_wdata = rf_wdata_q;
   assign o_busy = busy_q;
   assign o_done = done_q;
   assign o_fault = fault_q;
   assign o_branch = branch_q;
   // Bit 0 of the popped value selects the Thumb state, not the address.
   assign o_branch_addr = {tgt_q[31:1], 1'b0};
   assign o_tbit = tgt_q[0];
   assign o_flags_we = flags_we_q;
endmodule

// ==== test/lsu_mem_model.sv ====
// Purpose: Memory system model answering the unit's data bus.
// Assumes: One request outstanding; ack after i_wait + 1 request cycles without ack.
// Notes: Read data is a fixed pattern of the address.
`timescale 1ns/10ps
module lsu_mem_model #(
   parameter logic [31:0] PAT = 32'h0
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic [31:0] i_addr,
   input wire logic [1:0] i_wait,
   output logic o_ack,
   output logic [31:0] o_rdata
);
   logic [1:0] cnt;
   // Off the ack cycle the word is inverted, so an early or late
   // sample of the read bus shows up as wrong data.
   assign o_rdata = o_ack ? (i_addr ^ PAT) : ~(i_addr ^ PAT);
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ack <= 1'b0;
         cnt <= 2'h0;
      end else if (o_ack || !i_req) begin
         o_ack <= 1'b0;
         cnt <= 2'h0;
      end else if (cnt == i_wait) begin
         o_ack <= 1'b1;
      end else begin
         cnt <= cnt + 2'h1;
      end
   end
endmodule

// ==== test/lsu_checker.sv ====
// Purpose: Concurrent checks on the load/store unit ports.
// Assumes: Single clock domain, asynchronous active-high reset.
// Notes: Bound to every lsu_unit instance.
`timescale 1ns/10ps
module lsu_checker
   import lsu_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_start,
   input wire logic [15:0] i_instr,
   input wire logic [31:0] i_pc,
   input wire logic [31:0] i_sp,
   input wire logic [31:0] i_lr,
   input wire logic [255:0] i_lo_regs,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata,
   input wire logic o_mem_req,
   input wire logic o_mem_we,
   input wire logic [31:0] o_mem_addr,
   input wire lsu_pkg::lsu_size_t o_mem_size,
   input wire logic [31:0] o_mem_wdata,
   input wire logic o_rf_we,
   input wire logic [3:0] o_rf_waddr,
   input wire logic [31:0] o_rf_wdata,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_fault,
   input wire logic o_branch,
   input wire logic [31:0] o_branch_addr,
   input wire logic o_tbit,
   input wire logic o_flags_we
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   flags_never_a: assert property (!o_flags_we)
      else $error("flag write enable raised");
   req_hold_a: assert property (o_mem_req && !i_mem_ack |=>
      o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we)
      && $stable(o_mem_size) && $stable(o_mem_wdata))
      else $error("request changed before ack");
   addr_aligned_a: assert property (o_mem_req |->
      (o_mem_size == SZ_WORD) ? (o_mem_addr[1:0] == 2'h0) :
      (o_mem_size == SZ_HALF) ? !o_mem_addr[0] : (o_mem_size == SZ_BYTE))
      else $error("misaligned access issued");
   narrow_store_a: assert property (o_mem_req && o_mem_we |->
      (o_mem_size != SZ_BYTE || o_mem_wdata[31:8] == 24'h0) &&
      (o_mem_size != SZ_HALF || o_mem_wdata[31:16] == 16'h0))
      else $error("narrow store carries upper bits");
   fault_no_access_a: assert property (o_fault |->
      o_done && !o_mem_req && !$past(o_mem_req))
      else $error("faulting access reached memory");
   fault_quiet_a: assert property (o_fault |-> !o_rf_we && !o_branch)
      else $error("fault with register write or branch");
   branch_clean_a: assert property (o_branch |->
      o_done && !o_fault && o_rf_we && o_rf_waddr == REG_SP)
      else $error("branch before the pop completed");
   word_step_a: assert property (o_mem_req && i_mem_ack |=>
      (o_mem_req |-> o_mem_addr == $past(o_mem_addr) + 32'h4
      && o_mem_size == SZ_WORD))
      else $error("multiple transfer not ascending by one word");
   rf_target_a: assert property (o_rf_we |->
      o_rf_waddr <= 4'h7 || o_rf_waddr == REG_SP)
      else $error("write to a register outside the allowed set");
endmodule
bind lsu_unit lsu_checker lsu_checker_i (.i_clk, .i_rst, .i_start, .i_instr,
   .i_pc, .i_sp, .i_lr, .i_lo_regs, .i_mem_ack, .i_mem_rdata, .o_mem_req,
   .o_mem_we, .o_mem_addr, .o_mem_size, .o_mem_wdata, .o_rf_we, .o_rf_waddr,
   .o_rf_wdata, .o_busy, .o_done, .o_fault, .o_branch, .o_branch_addr,
   .o_tbit, .o_flags_we);

// ==== test/tb_load_store_unit.sv ====
// Purpose: Self-checking bench for the load/store unit.
// Assumes: Register file is held by the bench and not updated.
// Notes: Memory returns the address xor a pattern.
`timescale 1ns/10ps
module tb_load_store_unit;
   import lsu_pkg::*;
   localparam logic [31:0] PAT = 32'h8c3a_f0f1;
   localparam logic [31:0] SPV = 32'h2000_0100;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_start = 1'b0;
   logic [15:0] i_instr = 16'h0;
   logic [31:0] i_pc = 32'h0;
   logic [31:0] i_sp = SPV;
   logic [31:0] i_lr = 32'h0000_0a5b;
   logic [31:0] regs [8];
   logic [255:0] i_lo_regs;
   logic i_mem_ack, o_mem_req, o_mem_we, o_rf_we, o_busy, o_done, o_fault;
   logic o_branch, o_tbit, o_flags_we;
   logic [31:0] i_mem_rdata, o_mem_addr, o_mem_wdata, o_rf_wdata;
   logic [31:0] o_branch_addr, ba_s;
   lsu_size_t o_mem_size;
   logic [3:0] o_rf_waddr;
   logic [1:0] mem_wait = 2'h0;
   logic done_seen, fault_s, br_s, tbit_s;
   logic [66:0] acc_q [$];
   logic [35:0] rf_q [$];
   int err_total = 0;
   int n_tests = 0;
   always #20 i_clk = ~i_clk;
   always_comb for (int k = 0; k < 8; k++) i_lo_regs[32*k +: 32] = regs[k];
   lsu_unit lsu_unit_i (.i_clk, .i_rst, .i_start, .i_instr, .i_pc, .i_sp,
      .i_lr, .i_lo_regs, .i_mem_ack, .i_mem_rdata, .o_mem_req, .o_mem_we,
      .o_mem_addr, .o_mem_size, .o_mem_wdata, .o_rf_we, .o_rf_waddr,
      .o_rf_wdata, .o_busy, .o_done, .o_fault, .o_branch, .o_branch_addr,
      .o_tbit, .o_flags_we);
   lsu_mem_model #(.PAT(PAT)) lsu_mem_model_i (.i_clk, .i_rst,
      .i_req(o_mem_req), .i_addr(o_mem_addr), .i_wait(mem_wait),
      .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
   always @(posedge i_clk) begin
      if (o_mem_req === 1'b1 && i_mem_ack === 1'b1)
         acc_q.push_back({o_mem_we, o_mem_size, o_mem_addr,
            o_mem_we ? o_mem_wdata : 32'h0});
      if (o_rf_we === 1'b1)
         rf_q.push_back({o_rf_waddr, o_rf_wdata});
      if (o_done === 1'b1) begin
         done_seen = 1'b1;
         fault_s = o_fault;
         br_s = o_branch;
         tbit_s = o_tbit;
         ba_s = o_branch_addr;
      end
   end
   function automatic logic [31:0] ext(input logic [31:0] a,
         input lsu_size_t sz, input logic sg);
      logic [31:0] w;
      w = a ^ PAT;
      if (sz == SZ_BYTE)
         return sg ? {{24{w[7]}}, w[7:0]} : {24'h0, w[7:0]};
      if (sz == SZ_HALF)
         return sg ? {{16{w[15]}}, w[15:0]} : {16'h0, w[15:0]};
      return w;
   endfunction
   function automatic logic [31:0] trim(input logic [31:0] d,
         input lsu_size_t sz);
      if (sz == SZ_BYTE)
         return {24'h0, d[7:0]};
      return (sz == SZ_HALF) ? {16'h0, d[15:0]} : d;
   endfunction
   task automatic chk(input logic [66:0] got, input logic [66:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ca(input logic we, input lsu_size_t sz,
         input logic [31:0] a, input logic [31:0] d);
      chk(acc_q.size() ? acc_q.pop_front() : 'x, {we, sz, a, d});
   endtask
   task automatic cr(input logic [3:0] r, input logic [31:0] d);
      chk(rf_q.size() ? {31'h0, rf_q.pop_front()} : 'x, {r, d});
   endtask
   task automatic run(input logic [15:0] ins);
      @(negedge i_clk);
      acc_q.delete();
      rf_q.delete();
      done_seen = 1'b0;
      i_instr = ins;
      i_start = 1'b1;
      @(negedge i_clk);
      i_start = 1'b0;
      for (int n = 0; n < 40 && done_seen !== 1'b1; n++) @(negedge i_clk);
      chk({done_seen, o_busy}, 2'h2);
   endtask
   task automatic t_store_imm();
      run(16'h67d1);
      ca(1'b1, SZ_WORD, 32'h17c, regs[1]);
      run(16'h7011);
      ca(1'b1, SZ_BYTE, 32'h100, trim(regs[1], SZ_BYTE));
      run(16'h87d1);
      ca(1'b1, SZ_HALF, 32'h13e, trim(regs[1], SZ_HALF));
   endtask
   task automatic t_load_imm();
      run(16'h7fd3);
      ca(1'b0, SZ_BYTE, 32'h11f, 32'h0);
      cr(4'h3, ext(32'h11f, SZ_BYTE, 1'b0));
      run(16'h8fd3);
      ca(1'b0, SZ_HALF, 32'h13e, 32'h0);
      cr(4'h3, ext(32'h13e, SZ_HALF, 1'b0));
   endtask
   task automatic t_reg_ofs();
      lsu_size_t szt [8] = '{SZ_WORD, SZ_HALF, SZ_BYTE, SZ_BYTE, SZ_WORD,
         SZ_HALF, SZ_BYTE, SZ_HALF};
      for (int k = 0; k < 8; k++) begin
         run({4'h5, k[2:0], 9'h0d1});
         if (k < 3) begin
            ca(1'b1, szt[k], 32'h140, trim(regs[1], szt[k]));
         end else begin
            ca(1'b0, szt[k], 32'h140, 32'h0);
            cr(4'h1, ext(32'h140, szt[k], k == 3 || k == 7));
         end
      end
   endtask
   task automatic t_sp_lit();
      i_pc = 32'h102;
      run(16'h9dff);
      ca(1'b0, SZ_WORD, SPV + 32'h3fc, 32'h0);
      cr(4'h5, ext(SPV + 32'h3fc, SZ_WORD, 1'b0));
      run(16'h4eff);
      ca(1'b0, SZ_WORD, 32'h500, 32'h0);
      cr(4'h6, ext(32'h500, SZ_WORD, 1'b0));
   endtask
   task automatic t_fault();
      regs[3] = 32'h2;
      run(16'h58d1);
      chk({fault_s, acc_q.size() + rf_q.size()}, 33'h1_0000_0000);
      regs[3] = 32'h40;
      regs[2] = 32'h102;
      run(16'hc292);
      chk({fault_s, acc_q.size() + rf_q.size()}, 33'h1_0000_0000);
      regs[2] = 32'h100;
      run(16'h1c00);
      chk({fault_s, acc_q.size() + rf_q.size()}, 33'h0);
      run(16'hc800);
      chk({fault_s, acc_q.size() + rf_q.size()}, 33'h0);
   endtask
   task automatic t_multi();
      mem_wait = 2'h2;
      run(16'hc292);
      ca(1'b1, SZ_WORD, 32'h100, regs[1]);
      ca(1'b1, SZ_WORD, 32'h104, regs[4]);
      ca(1'b1, SZ_WORD, 32'h108, regs[7]);
      cr(4'h2, 32'h10c);
      run(16'hca05);
      ca(1'b0, SZ_WORD, 32'h100, 32'h0);
      ca(1'b0, SZ_WORD, 32'h104, 32'h0);
      cr(4'h0, ext(32'h100, SZ_WORD, 1'b0));
      cr(4'h2, ext(32'h104, SZ_WORD, 1'b0));
      chk(rf_q.size(), 0);
   endtask
   task automatic t_stack();
      logic [31:0] w;
      mem_wait = 2'h1;
      w = ext(SPV + 32'h4, SZ_WORD, 1'b0);
      run(16'hb504);
      ca(1'b1, SZ_WORD, SPV - 32'h8, regs[2]);
      ca(1'b1, SZ_WORD, SPV - 32'h4, i_lr);
      cr(REG_SP, SPV - 32'h8);
      run(16'hbd01);
      ca(1'b0, SZ_WORD, SPV, 32'h0);
      ca(1'b0, SZ_WORD, SPV + 32'h4, 32'h0);
      cr(4'h0, ext(SPV, SZ_WORD, 1'b0));
      cr(REG_SP, SPV + 32'h8);
      chk({br_s, tbit_s, ba_s}, {1'b1, w[0], w[31:1], 1'b0});
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      for (int k = 0; k < 8; k++) regs[k] = 32'hc0de_8a80 + k;
      regs[2] = 32'h100;
      regs[3] = 32'h40;
      repeat (2) @(negedge i_clk);
      i_rst = 1'b0;
      t_store_imm();
      t_load_imm();
      t_reg_ofs();
      t_sp_lit();
      t_fault();
      t_multi();
      t_stack();
      end_of_test();
   end
   // The full sequence needs well under a thousand cycles.
   initial begin
      repeat (3000) @(posedge i_clk);
      err_total++;
      end_of_test();
   end
endmodule
